// File: verilog/sarcp_pkg.sv
// Shared constants and types for the SAR converter serial port
package sarcp_pkg;

  // ==========================================================================
  // Result format
  localparam int RESULT_W = 18;

  // ==========================================================================
  // Conversion timing (internal clock domain, 25 MHz)
  localparam int CLK_HZ          = 25000000;
  localparam int CONV_TIME_NS    = 500;
  localparam int CONV_TIME_CYC   = (CONV_TIME_NS * (CLK_HZ / 1000000) + 999) / 1000;

  // ==========================================================================
  // Result FIFO
  localparam int FIFO_DEPTH = 32;

  // ==========================================================================
  // Interface mode chosen at conversion start
  typedef enum logic [1:0] {
    SARCP_MODE_3WIRE,
    SARCP_MODE_4WIRE,
    SARCP_MODE_CHAIN
  } sarcp_mode_t;

  // Synchronised view of the serial pins
  typedef struct packed {
    logic convert;
    logic data_in;
    logic sclk;
  } sarcp_pins_t;

endpackage : sarcp_pkg

// File: verilog/sarcp_fifo.sv
// Result FIFO between converter core and serial shifter
`timescale 1ns/1ps
module sarcp_fifo #(
  parameter int WIDTH = 18,
  parameter int DEPTH = 32
) (
  // Clock and reset
  input  wire logic             clk,
  input  wire logic             rst_n,
  // Fill side
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  // Drain side
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic      [WIDTH-1:0] out_data
);

  localparam int AW = $clog2(DEPTH);

  initial begin
    if (DEPTH < 2 || (1 << AW) != DEPTH) begin
      $error("sarcp_fifo: DEPTH must be a power of two, at least 2");
    end
  end

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0]      wr_ptr_reg;
  logic [AW:0]      rd_ptr_reg;
  logic             push;
  logic             pop;

  // Full when pointers differ only in the wrap bit
  assign in_ready  = !((wr_ptr_reg[AW] != rd_ptr_reg[AW]) && (wr_ptr_reg[AW-1:0] == rd_ptr_reg[AW-1:0]));
  assign out_valid = (wr_ptr_reg != rd_ptr_reg);
  assign out_data  = mem[rd_ptr_reg[AW-1:0]];
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;

  // ==========================================================================
  // Storage, no reset needed
  always_ff @(posedge clk) begin
    if (push) begin
      mem[wr_ptr_reg[AW-1:0]] <= in_data;
    end
  end

  // Pointers
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
    end else begin
      if (push) begin
        wr_ptr_reg <= wr_ptr_reg + 1'b1;
      end
      if (pop) begin
        rd_ptr_reg <= rd_ptr_reg + 1'b1;
      end
    end
  end

endmodule : sarcp_fifo

// File: verilog/sarcp_port.sv
// Conversion control and serial read-out port of an 18-bit differential SAR converter
`timescale 1ns/1ps
module sarcp_port #(
  parameter int RESULT_W   = sarcp_pkg::RESULT_W,
  parameter int FIFO_DEPTH = sarcp_pkg::FIFO_DEPTH,
  parameter int CONV_CYC   = sarcp_pkg::CONV_TIME_CYC
) (
  // Clock and reset
  input  wire logic                       clk,
  input  wire logic                       rst_n,
  // Host pins
  input  wire logic                       convert_start_in,
  input  wire logic                       data_in,
  input  wire logic                       sclk,
  output logic                            data_out,
  // Sampled differential code from the analog core
  input  wire logic signed [RESULT_W-1:0] sample_code,
  // Status
  output logic                            busy,
  output logic                            overrun,
  output sarcp_pkg::sarcp_mode_t          mode
);

  initial begin
    if (RESULT_W < 2 || RESULT_W > 32 || CONV_CYC < 1) begin
      $error("sarcp_port: unsupported parameter values");
    end
  end

  // ==========================================================================
  // Pin synchronisers: two flops before any logic looks
  sarcp_pkg::sarcp_pins_t meta_reg;
  sarcp_pkg::sarcp_pins_t sync_reg;
  sarcp_pkg::sarcp_pins_t prev_reg;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_reg <= '0;
      sync_reg <= '0;
      prev_reg <= '0;
    end else begin
      meta_reg <= '{convert: convert_start_in, data_in: data_in, sclk: sclk};
      sync_reg <= meta_reg;
      prev_reg <= sync_reg;
    end
  end

  logic conv_rise;
  logic sclk_fall;
  assign conv_rise = sync_reg.convert && !prev_reg.convert;
  assign sclk_fall = !sync_reg.sclk && prev_reg.sclk;

  // ==========================================================================
  // Conversion state, declared ahead of the mode latch that reads it
  typedef enum logic [1:0] {
    SARCP_ACQ,
    SARCP_CONV
  } sarcp_state_t;

  localparam int CW = $clog2(CONV_CYC + 1);

  sarcp_state_t  state_reg;
  logic [CW-1:0] conv_cnt_reg;
  logic          busy_reg;
  logic          push_reg;
  logic signed [RESULT_W-1:0] code_reg;
  logic          fifo_in_ready;

  assign busy_reg = (state_reg == SARCP_CONV);

  // ==========================================================================
  // Mode latch: data-in level at convert edge, held until the next start
  sarcp_pkg::sarcp_mode_t mode_reg;
  logic                   chain_req_reg;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      mode_reg      <= sarcp_pkg::SARCP_MODE_3WIRE;
      chain_req_reg <= 1'b0;
    end else if (conv_rise && !busy_reg) begin
      // High data-in selects chip-select operation; low selects daisy-chain
      if (sync_reg.data_in) begin
        mode_reg <= sync_reg.convert ? sarcp_pkg::SARCP_MODE_3WIRE : sarcp_pkg::SARCP_MODE_4WIRE;
      end else begin
        mode_reg <= sarcp_pkg::SARCP_MODE_CHAIN;
      end
      chain_req_reg <= !sync_reg.data_in;
    end
  end

  // ==========================================================================
  // Conversion timer on the internal clock
  // Conversion runs on clk only; serial clock plays no part here
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_reg    <= SARCP_ACQ;
      conv_cnt_reg <= '0;
      push_reg     <= 1'b0;
      code_reg     <= '0;
    end else begin
      push_reg <= 1'b0;
      case (state_reg)
        SARCP_ACQ: begin
          if (conv_rise) begin
            state_reg    <= SARCP_CONV;
            conv_cnt_reg <= CW'(CONV_CYC - 1);
            code_reg     <= sample_code;
          end
        end
        SARCP_CONV: begin
          if (conv_cnt_reg == '0) begin
            state_reg <= SARCP_ACQ;
            push_reg  <= 1'b1;
          end else begin
            conv_cnt_reg <= conv_cnt_reg - 1'b1;
          end
        end
        default: begin
          state_reg <= SARCP_ACQ;
        end
      endcase
    end
  end

  // ==========================================================================
  // Result FIFO; a full FIFO drops the result and flags overrun
  logic                fifo_out_valid;
  logic                fifo_out_ready;
  logic [RESULT_W-1:0] fifo_out_data;

  sarcp_fifo #(
    .WIDTH (RESULT_W),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .clk       (clk),
    .rst_n     (rst_n),
    .in_valid  (push_reg),
    .in_ready  (fifo_in_ready),
    .in_data   (code_reg),
    .out_valid (fifo_out_valid),
    .out_ready (fifo_out_ready),
    .out_data  (fifo_out_data)
  );

  // ==========================================================================
  // Chip-select by mode: convert in 3-wire, data-in in 4-wire
  logic select_active;
  always_comb begin
    select_active = 1'b0;
    case (mode_reg)
      sarcp_pkg::SARCP_MODE_3WIRE: select_active = !sync_reg.convert;
      sarcp_pkg::SARCP_MODE_4WIRE: select_active = !sync_reg.data_in;
      default:                     select_active = !sync_reg.convert;
    endcase
  end

  // ==========================================================================
  // Serial shifter: loads a word when selected and idle, shifts on SCLK fall
  localparam int SW = $clog2(RESULT_W + 1);

  logic [RESULT_W-1:0] shift_reg;
  logic [SW-1:0]       bits_left_reg;
  logic                data_out_reg;
  logic                load;

  // Loading only outside conversion; the convert rise starting a conversion deselects in 3-wire and chain mode and aborts a word already loaded
  assign load           = select_active && !busy_reg && (bits_left_reg == '0) && fifo_out_valid;
  assign fifo_out_ready = load;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      shift_reg     <= '0;
      bits_left_reg <= '0;
      data_out_reg  <= 1'b0;
    end else if (!select_active) begin
      // Deselect aborts any partial word
      bits_left_reg <= '0;
      data_out_reg  <= 1'b0;
    end else if (load) begin
      shift_reg     <= fifo_out_data;
      bits_left_reg <= SW'(RESULT_W);
      data_out_reg  <= fifo_out_data[RESULT_W-1];
    end else if (sclk_fall && bits_left_reg != '0) begin
      // Daisy-chain feeds data-in in behind the result
      shift_reg     <= {shift_reg[RESULT_W-2:0], chain_req_reg ? sync_reg.data_in : 1'b0};
      bits_left_reg <= bits_left_reg - 1'b1;
      data_out_reg  <= shift_reg[RESULT_W-2];
    end
  end

  // ==========================================================================
  // Status outputs, all registered
  logic overrun_reg;
  logic busy_out_reg;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      overrun_reg  <= 1'b0;
      busy_out_reg <= 1'b0;
    end else begin
      busy_out_reg <= busy_reg;
      if (push_reg && !fifo_in_ready) begin
        overrun_reg <= 1'b1;
      end
    end
  end

  assign data_out = data_out_reg;
  assign busy     = busy_out_reg;
  assign overrun  = overrun_reg;
  assign mode     = mode_reg;

endmodule : sarcp_port

// File: test/sarcp_port_asserts.sv
// Concurrent checks on the pins of the converter serial port
`timescale 1ns/1ps
module sarcp_port_asserts #(
  parameter int RESULT_W = 18,
  parameter int CONV_CYC = 13
) (
  // Clock and reset
  input wire logic                       clk,
  input wire logic                       rst_n,
  // Host pins
  input wire logic                       convert_start_in,
  input wire logic                       data_in,
  input wire logic                       sclk,
  input wire logic                       data_out,
  // Analog core code
  input wire logic signed [RESULT_W-1:0] sample_code,
  // Status
  input wire logic                       busy,
  input wire logic                       overrun,
  input wire sarcp_pkg::sarcp_mode_t     mode
);
  logic [7:0] quiet_reg;
  logic [7:0] busy_cnt_reg;
  logic       cv_reg;
  logic       sc_reg;
  logic       din_at_reg;
  // ==========================================================================
  // Helpers: quiet time of the convert and sclk pins, busy length, data_in level at convert rise
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      quiet_reg <= 8'h00;
      busy_cnt_reg <= 8'h00;
      cv_reg <= 1'b0;
      sc_reg <= 1'b1;
      din_at_reg <= 1'b1;
    end else begin
      cv_reg <= convert_start_in;
      sc_reg <= sclk;
      quiet_reg <= (convert_start_in != cv_reg || sclk != sc_reg) ? 8'h00 : quiet_reg + {7'h00, quiet_reg != 8'hff};
      busy_cnt_reg <= busy ? busy_cnt_reg + 8'h01 : 8'h00;
      if (convert_start_in && !cv_reg) din_at_reg <= data_in;
    end
  end
  // ==========================================================================
  // Properties
  reset_state_a: assert property (@(posedge clk) disable iff (!rst_n) $rose(rst_n) |->
    !busy && !overrun && !data_out && mode == sarcp_pkg::SARCP_MODE_3WIRE) else $error("bad state after reset");
  busy_start_a: assert property (@(posedge clk) disable iff (!rst_n)
    $rose(convert_start_in) && !busy |-> ##[2:7] busy) else $error("convert rise did not start busy");
  busy_len_a: assert property (@(posedge clk) disable iff (!rst_n)
    $fell(busy) |-> busy_cnt_reg == CONV_CYC) else $error("conversion length wrong");
  mode_hold_a: assert property (@(posedge clk) disable iff (!rst_n)
    busy |-> $stable(mode)) else $error("mode moved during conversion");
  mode_pick_a: assert property (@(posedge clk) disable iff (!rst_n) $rose(busy) |->
    mode == (din_at_reg ? sarcp_pkg::SARCP_MODE_3WIRE : sarcp_pkg::SARCP_MODE_CHAIN)) else $error("mode pick wrong");
  dout_quiet_a: assert property (@(posedge clk) disable iff (!rst_n)
    $changed(data_out) |-> quiet_reg < 8'h08) else $error("data_out moved without a pin edge");
  deselect_low_a: assert property (@(posedge clk) disable iff (!rst_n)
    (mode == sarcp_pkg::SARCP_MODE_3WIRE && convert_start_in)[*5] |-> !data_out) else $error("deselected output high");
  overrun_stick_a: assert property (@(posedge clk) disable iff (!rst_n)
    overrun |=> overrun) else $error("overrun cleared");
endmodule : sarcp_port_asserts

bind sarcp_port sarcp_port_asserts #(.RESULT_W(RESULT_W), .CONV_CYC(CONV_CYC)) sarcp_port_asserts_i (
  .clk(clk), .rst_n(rst_n), .convert_start_in(convert_start_in), .data_in(data_in), .sclk(sclk),
  .data_out(data_out), .sample_code(sample_code), .busy(busy), .overrun(overrun), .mode(mode));

// File: test/sarcp_host.sv
// Host model that drives the converter pins from the bench clock
`timescale 1ns/1ps
module sarcp_host (
  // Bench clock
  input  wire logic clk,
  // Host pins
  output logic      convert_start_in,
  output logic      data_in,
  output logic      sclk,
  input  wire logic data_out
);
  // Idle: serial clock parked high, stands still between frames
  initial begin
    convert_start_in = 1'b0;
    data_in = 1'b1;
    sclk = 1'b1;
  end
  // One convert pulse: low from the 2nd to the 5th clock, rise at the 5th.
  // Called back to back, the low phase falls inside the running 4-clock
  // conversion, so a chain of starts never selects the port while idle.
  task automatic start(input logic chip_sel);
    repeat (2) @(posedge clk);
    convert_start_in <= 1'b0;
    data_in          <= chip_sel;
    repeat (3) @(posedge clk);
    convert_start_in <= 1'b1;
  endtask : start
  // Convert pin low selects in three-wire mode
  task automatic select(input logic on);
    convert_start_in <= !on;
    repeat (8) @(posedge clk);
  endtask : select
  // One word; half periods of 4 clocks give the 320 ns serial clock
  task automatic read_word(output logic [17:0] w);
    for (int i = 17; i >= 0; i--) begin
      repeat (4) @(posedge clk);
      w[i] = data_out;
      sclk <= 1'b0;
      repeat (4) @(posedge clk);
      sclk <= 1'b1;
    end
  endtask : read_word
endmodule : sarcp_host

// File: test/sarcp_port_tb_top.sv
// Self-checking bench for the converter serial port
`timescale 1ns/1ps
module sarcp_port_tb_top;
  logic                   clk, rst_n, conv, din, sclk, dout, busy, overrun;
  logic signed [17:0]     code;
  sarcp_pkg::sarcp_mode_t mode;
  int                     error_cnt = 0;
  int                     n_compared = 0;
  // 25 MHz clock
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  sarcp_host sarcp_host_i (.clk(clk), .convert_start_in(conv), .data_in(din), .sclk(sclk), .data_out(dout));
  // Short conversion keeps the run brief
  sarcp_port #(.CONV_CYC(4)) sarcp_port_i (.clk(clk), .rst_n(rst_n), .convert_start_in(conv), .data_in(din),
    .sclk(sclk), .data_out(dout), .sample_code(code), .busy(busy), .overrun(overrun), .mode(mode));
  // Code for conversion n, negative (MSB set) for every n the bench uses
  function automatic logic [17:0] code_of(input int n);
    return 18'(n * 18'h0b3d) ^ 18'h2a5a5;
  endfunction : code_of
  task automatic chk(input string what, input logic [17:0] exp, input logic [17:0] got);
    n_compared++;
    if (got !== exp) begin
      error_cnt++;
      $display("mismatch %s exp %h got %h", what, exp, got);
    end
  endtask : chk
  task automatic final_report;
    $display("compared %0d mismatches %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : final_report
  // Back-to-back chain starts fill the FIFO until it drops a word, then one
  // three-wire start; each pass judges the conversion begun on the pass before
  task automatic fill_test;
    for (int n = 0; n < 34; n++) begin
      sarcp_host_i.start(n == 33);
      code <= code_of(n);
      if (n > 0) begin
        chk("busy", 18'h00001, {17'h00000, busy});
        chk("mode", {16'h0000, sarcp_pkg::SARCP_MODE_CHAIN}, {16'h0000, mode});
      end
      chk("overrun", 18'h00000, {17'h00000, overrun});
    end
    repeat (10) @(posedge clk);
    chk("busy", 18'h00000, {17'h00000, busy});
    chk("overrun", 18'h00001, {17'h00000, overrun});
  endtask : fill_test
  // Three-wire readout drains all kept words, MSB first, then deselects
  task automatic drain_test;
    logic [17:0] w;
    chk("mode", {16'h0000, sarcp_pkg::SARCP_MODE_3WIRE}, {16'h0000, mode});
    sarcp_host_i.select(1'b1);
    for (int n = 0; n < 32; n++) begin
      sarcp_host_i.read_word(w);
      chk("word", code_of(n), w);
    end
    sarcp_host_i.select(1'b0);
    chk("deselected", 18'h00000, {17'h00000, dout});
  endtask : drain_test
  // Reset for two cycles, then the scenarios
  initial begin
    rst_n = 1'b0;
    code = 18'sh00000;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    repeat (4) @(posedge clk);
    fill_test();
    drain_test();
    final_report();
  end
endmodule : sarcp_port_tb_top
